// ---- pkg/ppc_pkg.sv ----
// Package with register map, reset values and shared types of the port pin control block.
package ppc_pkg;
  localparam int unsigned PPC_W = 8;
  localparam logic [7:0] PPC_OFF_P2_LATCH  = 8'hA0;
  localparam logic [7:0] PPC_OFF_P2_INCFG  = 8'hA5;
  localparam logic [7:0] PPC_OFF_P2_DRIVE  = 8'hA6;
  localparam logic [7:0] PPC_OFF_P3_LATCH  = 8'hB0;
  localparam logic [7:0] PPC_OFF_P2_BYPASS = 8'hD6;
  localparam logic [7:0] PPC_OFF_P3_INCFG  = 8'hF4;
  localparam logic [7:0] PPC_RST_P2_LATCH  = 8'hFF;
  localparam logic [7:0] PPC_RST_P2_INCFG  = 8'hFF;
  localparam logic [7:0] PPC_RST_P2_DRIVE  = 8'h00;
  localparam logic [7:0] PPC_RST_P3_LATCH  = 8'hFF;
  localparam logic [7:0] PPC_RST_P2_BYPASS = 8'h00;
  localparam logic [7:0] PPC_RST_P3_INCFG  = 8'hFF;
  localparam logic [7:0] PPC_P3_SMALL_MASK = 8'h01;
  localparam logic [7:0] PPC_P3_LARGE_MASK = 8'hFF;
  localparam logic [7:0] PPC_P3_DRIVE      = 8'hFF;
  typedef logic [7:0] ppc_byte_t;
endpackage

// ---- pkg/ppc_pin_if.sv ----
// Interface carrying one port's configuration and pin signals between the modules.
interface ppc_pin_if;
  logic [7:0] latch;
  logic [7:0] incfg;
  logic [7:0] drive;
  logic [7:0] present;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [7:0] rd_value;
  modport ctrl (output latch, incfg, drive, present, pin_in, input pin_out, pin_oe, rd_value);
  modport pad  (input latch, incfg, drive, present, pin_in, output pin_out, pin_oe, rd_value);
endinterface

// ---- verilog/ppc_pad_bank.sv ----
// Pad logic of one eight-pin port: drive, enable and readback per pin.
module ppc_pad_bank (
  ppc_pin_if.pad p
);
  import ppc_pkg::*;
  generate
    for (genvar i = 0; i < 8; i++) begin : g_pin
      always_comb begin
        // Analog pins have no driver and no receiver; the drive mode is ignored.
        if (!p.incfg[i] || !p.present[i]) begin
          p.pin_out[i] = 1'b0;
          p.pin_oe[i]  = 1'b0;
        end else if (p.latch[i]) begin
          p.pin_out[i] = 1'b1;
          p.pin_oe[i]  = p.drive[i];
        end else begin
          p.pin_out[i] = 1'b0;
          p.pin_oe[i]  = 1'b1;
        end
        p.rd_value[i] = p.incfg[i] ? p.pin_in[i] : 1'b0;
      end
    end
  endgenerate
endmodule

// ---- verilog/ppc_top.sv ----
// Port 2 and port 3 pin control registers and pad control.
module ppc_top #(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  // Clock and reset.
  input  wire  logic             clk_sys,
  input  wire  logic             reset_n,
  // Register port.
  input  wire  logic [7:0]       reg_addr,
  input  wire  logic [7:0]       reg_wdata,
  input  wire  logic             reg_wr,
  input  wire  logic             reg_rd,
  output       ppc_pkg::ppc_byte_t reg_rdata,
  // Port 2 pins.
  input  wire  logic [7:0]       p2_pin_in,
  output       ppc_pkg::ppc_byte_t p2_pin_out,
  output       ppc_pkg::ppc_byte_t p2_pin_oe,
  output       ppc_pkg::ppc_byte_t p2_pullup_en,
  // Port 3 pins.
  input  wire  logic [7:0]       p3_pin_in,
  output       ppc_pkg::ppc_byte_t p3_pin_out,
  output       ppc_pkg::ppc_byte_t p3_pin_oe,
  // Matrix bypass to the pin-assignment matrix.
  output       ppc_pkg::ppc_byte_t p2_matrix_skip
);
  import ppc_pkg::*;

  // ==========================================================
  // Registers
  ppc_byte_t second_port_latch_r, second_port_latch_nxt;
  ppc_byte_t second_port_input_config_r, second_port_input_config_nxt;
  ppc_byte_t second_port_drive_config_r, second_port_drive_config_nxt;
  ppc_byte_t third_port_latch_r, third_port_latch_nxt;
  ppc_byte_t third_port_input_config_r, third_port_input_config_nxt;
  ppc_byte_t second_port_bypass_bits_r, second_port_bypass_bits_nxt;
  ppc_byte_t rdata_r, rdata_nxt;
  ppc_byte_t p2_out_r, p2_oe_r, p2_pu_r, p3_out_r, p3_oe_r;
  ppc_byte_t p2_out_nxt, p2_oe_nxt, p2_pu_nxt, p3_out_nxt, p3_oe_nxt;
  ppc_byte_t p3_present;

  ppc_pin_if p2_if ();
  ppc_pin_if p3_if ();

  assign p3_present = LARGE_PACKAGE ? PPC_P3_LARGE_MASK : PPC_P3_SMALL_MASK;

  function automatic ppc_byte_t wr_reg(input ppc_byte_t cur, input logic [7:0] off);
    wr_reg = (reg_wr && reg_addr == off) ? reg_wdata : cur;
  endfunction

  always_comb begin
    second_port_latch_nxt        = wr_reg(second_port_latch_r, PPC_OFF_P2_LATCH);
    second_port_input_config_nxt = wr_reg(second_port_input_config_r, PPC_OFF_P2_INCFG);
    second_port_drive_config_nxt = wr_reg(second_port_drive_config_r, PPC_OFF_P2_DRIVE);
    // All eight bits store even on the small package.
    third_port_latch_nxt         = wr_reg(third_port_latch_r, PPC_OFF_P3_LATCH);
    third_port_input_config_nxt  = wr_reg(third_port_input_config_r, PPC_OFF_P3_INCFG);
    second_port_bypass_bits_nxt  = wr_reg(second_port_bypass_bits_r, PPC_OFF_P2_BYPASS);
  end

  // ==========================================================
  // Pad banks
  assign p2_if.latch   = second_port_latch_r;
  assign p2_if.incfg   = second_port_input_config_r;
  assign p2_if.drive   = second_port_drive_config_r;
  assign p2_if.present = PPC_P3_LARGE_MASK;
  assign p2_if.pin_in  = p2_pin_in;
  assign p3_if.latch   = third_port_latch_r;
  assign p3_if.incfg   = third_port_input_config_r;
  assign p3_if.drive   = PPC_P3_DRIVE;
  assign p3_if.present = p3_present;
  assign p3_if.pin_in  = p3_pin_in;

  ppc_pad_bank u_p2 (.p(p2_if.pad));
  ppc_pad_bank u_p3 (.p(p3_if.pad));

  // ==========================================================
  // Read data
  // The latch offsets return the pad readback, not the stored latch value.
  // A digital pin therefore shows the level that stands on the pin, so an
  // open-drain one held low from outside reads zero although its latch is one.
  // Analog pins are forced to zero inside the pad bank, and absent port 3
  // pins are masked here so that a stored but unused latch bit never shows.
  // Offsets that map to no register read as zero and ignore writes.
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        PPC_OFF_P2_LATCH:  rdata_nxt = p2_if.rd_value;
        PPC_OFF_P2_INCFG:  rdata_nxt = second_port_input_config_r;
        PPC_OFF_P2_DRIVE:  rdata_nxt = second_port_drive_config_r;
        PPC_OFF_P3_LATCH:  rdata_nxt = p3_if.rd_value & p3_present;
        PPC_OFF_P3_INCFG:  rdata_nxt = third_port_input_config_r;
        PPC_OFF_P2_BYPASS: rdata_nxt = second_port_bypass_bits_r;
        default:           rdata_nxt = 8'h00;
      endcase
    end
  end

  // Read data stand for exactly one cycle after the strobe, then fall to zero.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================
  // Configuration registers
  // Every register takes its new value at the edge on which the write strobe
  // is sampled; the pins follow one cycle later through the pin registers.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      second_port_latch_r        <= PPC_RST_P2_LATCH;
      second_port_input_config_r <= PPC_RST_P2_INCFG;
      second_port_drive_config_r <= PPC_RST_P2_DRIVE;
      third_port_latch_r         <= PPC_RST_P3_LATCH;
      third_port_input_config_r  <= PPC_RST_P3_INCFG;
      second_port_bypass_bits_r  <= PPC_RST_P2_BYPASS;
    end else begin
      second_port_latch_r        <= second_port_latch_nxt;
      second_port_input_config_r <= second_port_input_config_nxt;
      second_port_drive_config_r <= second_port_drive_config_nxt;
      third_port_latch_r         <= third_port_latch_nxt;
      third_port_input_config_r  <= third_port_input_config_nxt;
      second_port_bypass_bits_r  <= second_port_bypass_bits_nxt;
    end
  end

  // ==========================================================
  // Pin outputs
  // The pad banks decide drive level and enable per pin; these registers
  // only retime them so that every pin output comes from a flip-flop and
  // cannot glitch while the configuration registers change.
  // The weak pull-up follows the input configuration: an analog pin loses
  // its pull-up together with its driver and receiver.
  // Port 3 is always push-pull, and its absent pins keep the enable low.
  always_comb begin
    p2_out_nxt = p2_if.pin_out;
    p2_oe_nxt  = p2_if.pin_oe;
    p2_pu_nxt  = second_port_input_config_r;
    p3_out_nxt = p3_if.pin_out;
    p3_oe_nxt  = p3_if.pin_oe;
  end

  // During reset every pin floats: no drive and no pull-up.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      p2_out_r <= 8'h00;
      p2_oe_r  <= 8'h00;
      p2_pu_r  <= 8'h00;
      p3_out_r <= 8'h00;
      p3_oe_r  <= 8'h00;
    end else begin
      p2_out_r <= p2_out_nxt;
      p2_oe_r  <= p2_oe_nxt;
      p2_pu_r  <= p2_pu_nxt;
      p3_out_r <= p3_out_nxt;
      p3_oe_r  <= p3_oe_nxt;
    end
  end

  // ==========================================================
  // Outputs
  // The bypass bits go to the matrix as a plain level straight from their
  // register; software should set them for analog and special-function pins.
  assign reg_rdata      = rdata_r;
  assign p2_pin_out     = p2_out_r;
  assign p2_pin_oe      = p2_oe_r;
  assign p2_pullup_en   = p2_pu_r;
  assign p3_pin_out     = p3_out_r;
  assign p3_pin_oe      = p3_oe_r;
  assign p2_matrix_skip = second_port_bypass_bits_r;
endmodule

// ---- verification/ppc_top_props.sv ----
// Checker of the port pin control block.
module ppc_top_props
  import ppc_pkg::*;
#(parameter bit LARGE_PACKAGE = 1'b1) (
  // Clock, reset and register port.
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire ppc_byte_t  reg_rdata,
  // Pins and matrix.
  input wire logic [7:0] p2_pin_in,
  input wire ppc_byte_t  p2_pin_out,
  input wire ppc_byte_t  p2_pin_oe,
  input wire ppc_byte_t  p2_pullup_en,
  input wire logic [7:0] p3_pin_in,
  input wire ppc_byte_t  p3_pin_out,
  input wire ppc_byte_t  p3_pin_oe,
  input wire ppc_byte_t  p2_matrix_skip
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shadow copies of the port 2 registers; the count holds off checks for two edges after a write.
  ppc_byte_t lat_r, inc_r, drv_r, skp_r, lat_nxt, inc_nxt, drv_nxt, skp_nxt;
  logic [1:0] qc_r, qc_nxt;
  // Pins that exist on port 3 for the chosen package.
  localparam logic [7:0] p3_mask = LARGE_PACKAGE ? PPC_P3_LARGE_MASK : PPC_P3_SMALL_MASK;
  always_comb begin
    {lat_nxt, inc_nxt, drv_nxt, skp_nxt} = {lat_r, inc_r, drv_r, skp_r};
    qc_nxt = reg_wr ? 2'h0 : qc_r + {1'b0, qc_r != 2'h2};
    if (reg_wr && reg_addr == PPC_OFF_P2_LATCH) lat_nxt = reg_wdata;
    if (reg_wr && reg_addr == PPC_OFF_P2_INCFG) inc_nxt = reg_wdata;
    if (reg_wr && reg_addr == PPC_OFF_P2_DRIVE) drv_nxt = reg_wdata;
    if (reg_wr && reg_addr == PPC_OFF_P2_BYPASS) skp_nxt = reg_wdata;
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      {lat_r, inc_r, drv_r, skp_r} <= {PPC_RST_P2_LATCH, PPC_RST_P2_INCFG, PPC_RST_P2_DRIVE, PPC_RST_P2_BYPASS};
      qc_r <= 2'h0;
    end else begin
      {lat_r, inc_r, drv_r, skp_r} <= {lat_nxt, inc_nxt, drv_nxt, skp_nxt};
      qc_r <= qc_nxt;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence quiet_s; qc_r == 2'h2; endsequence
  sequence rd_p2_s; reg_rd && reg_addr == PPC_OFF_P2_LATCH; endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
  a_read_pin: assert property (rd_p2_s |=> reg_rdata == ($past(p2_pin_in) & $past(inc_r)))
    else $error("read is not pin level");
  a_read_analog: assert property (rd_p2_s |=> (reg_rdata & ~$past(inc_r)) == 8'h00)
    else $error("analog bit read nonzero");
  a_oe_mode: assert property (quiet_s |-> p2_pin_oe == (inc_r & (drv_r | ~lat_r)))
    else $error("output enable wrong");
  a_out_level: assert property (quiet_s |-> (p2_pin_out & p2_pin_oe) == (lat_r & p2_pin_oe))
    else $error("driven level wrong");
  a_pullup_off: assert property (quiet_s |-> p2_pullup_en == inc_r) else $error("pull-up wrong");
  a_skip_level: assert property (quiet_s |-> p2_matrix_skip == skp_r) else $error("skip wrong");
  a_p3_present: assert property (quiet_s |-> p3_pin_oe == p3_mask)
    else $error("port 3 enable wrong");
endmodule
bind ppc_top ppc_top_props #(.LARGE_PACKAGE(LARGE_PACKAGE)) u_ppc_top_props (.clk_sys(clk_sys), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .p2_pin_in(p2_pin_in), .p2_pin_out(p2_pin_out), .p2_pin_oe(p2_pin_oe), .p2_pullup_en(p2_pullup_en),
  .p3_pin_in(p3_pin_in), .p3_pin_out(p3_pin_out), .p3_pin_oe(p3_pin_oe), .p2_matrix_skip(p2_matrix_skip));

// ---- verification/ppc_pin_model.sv ----
// Model of the circuitry on the port 2 pins.
module ppc_pin_model (
  // Device side.
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pullup_en,
  input wire logic       clk_sys,
  // Outside loads pulling pins low.
  input wire logic [7:0] ext_low,
  // Resolved pin level.
  output logic     [7:0] pin_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] float_r = 8'h55;
  // An undriven pin without pull-up wanders every clock, unless an outside load holds it low and it reads a steady zero.
  always @(posedge clk_sys) float_r <= ~float_r;
  always_comb pin_lvl = (pin_oe & pin_out) | (~pin_oe & ~ext_low & (pullup_en | float_r));
endmodule

// ---- verification/tb.sv ----
// Testbench of the port pin control block.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ppc_pkg::*;
  logic clk_sys = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, ext_low = 8'h89, p2_pin_in;
  ppc_byte_t reg_rdata, p2_pin_out, p2_pin_oe, p2_pullup_en, p3_pin_out, p3_pin_oe, p2_matrix_skip;
  wire logic [7:0] p3_pin_in = (p3_pin_oe & p3_pin_out) | ~p3_pin_oe;
  int bad_count = 0, compares = 0, cycles = 0;
  ppc_top u_ppc_top (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .p2_pin_in(p2_pin_in), .p2_pin_out(p2_pin_out),
    .p2_pin_oe(p2_pin_oe), .p2_pullup_en(p2_pullup_en), .p3_pin_in(p3_pin_in), .p3_pin_out(p3_pin_out),
    .p3_pin_oe(p3_pin_oe), .p2_matrix_skip(p2_matrix_skip));
  ppc_pin_model u_ppc_pin_model (.pin_out(p2_pin_out), .pin_oe(p2_pin_oe), .pullup_en(p2_pullup_en),
    .clk_sys(clk_sys), .ext_low(ext_low), .pin_lvl(p2_pin_in));
  initial forever #2.5 clk_sys = ~clk_sys;
  task automatic cmp(input ppc_byte_t got, input ppc_byte_t exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input ppc_byte_t exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    cmp(reg_rdata, exp);
    @(posedge clk_sys);
  endtask
  task automatic stop_test;
    $display("Counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    cmp(p2_pin_oe, 8'h00);
    cmp(p2_pin_out, 8'hFF);
    @(posedge clk_sys);
    rd(PPC_OFF_P2_LATCH, 8'h76);
    $display("reset test done");
    wr(PPC_OFF_P2_DRIVE, 8'hF0);
    wr(PPC_OFF_P2_LATCH, 8'h5A);
    @(negedge clk_sys);
    cmp(p2_pin_oe, 8'hF5);
    cmp(p2_pin_out & p2_pin_oe, 8'h50);
    @(posedge clk_sys);
    rd(PPC_OFF_P2_LATCH, 8'h52);
    $display("drive test done");
    wr(PPC_OFF_P2_BYPASS, 8'hF0);
    wr(PPC_OFF_P2_INCFG, 8'h0F);
    @(negedge clk_sys);
    cmp(p2_matrix_skip, 8'hF0);
    cmp(p2_pin_oe, 8'h05);
    cmp(p2_pullup_en, 8'h0F);
    @(posedge clk_sys);
    rd(PPC_OFF_P2_LATCH, 8'h02);
    $display("analog test done");
    wr(PPC_OFF_P3_LATCH, 8'h3C);
    @(negedge clk_sys);
    cmp(p3_pin_oe, 8'hFF);
    cmp(p3_pin_out, 8'h3C);
    @(posedge clk_sys);
    rd(PPC_OFF_P3_LATCH, 8'h3C);
    wr(8'h55, 8'hA5);
    rd(8'h55, 8'h00);
    rd(PPC_OFF_P2_DRIVE, 8'hF0);
    $display("port 3 and map test done");
    stop_test();
  end
endmodule
